//--- logic/eal_pkg.sv
// constants and carrier types for the configuration autoloader
package eal_pkg;
   localparam logic [15:0] PATTERN       = 16'h5AA5;
   localparam logic [15:0] WORD_PATTERN  = 16'h0000;
   localparam logic [15:0] WORD_COUNT    = 16'h0001;
   localparam logic [15:0] WORD_OPT      = 16'h0002;
   localparam logic [15:0] WORD_MAC0     = 16'h0003;
   localparam logic [15:0] WORD_MAC2     = 16'h0005;
   localparam int          OPT_PHY_LSB   = 8;
   localparam int          OPT_TYPE_BIT  = 5;
   localparam int          OPT_POL_BIT   = 4;
   localparam int          OPT_SIG_BIT   = 2;
   localparam logic [7:0]  SIG_SET       = 8'h57;
   localparam logic [7:0]  SIG_CLR       = 8'h42;
   localparam logic [7:0]  SIG_HIGH      = 8'h57;
   localparam logic [2:0]  PHY_AUTO_ALL  = 3'h0;
   localparam logic [2:0]  PHY_M100_FDX  = 3'h4;
   localparam logic [2:0]  PHY_M100_HDX  = 3'h5;
   localparam logic [2:0]  PHY_M10_FDX   = 3'h6;
   localparam logic [2:0]  PHY_M10_HDX   = 3'h7;
   localparam logic [15:0] CSR_LAST      = 16'h001F;
   localparam logic [15:0] LOW_LAST      = 16'h001F;
   localparam logic [15:0] HIGH_BASE     = 16'h0400;
   localparam logic [15:0] HIGH_LAST     = 16'h040F;
   localparam logic [15:0] BUF_BASE      = 16'h4000;
   localparam logic [15:0] BUF_LAST      = 16'h7FFF;
   localparam logic [4:0]  LOW_MAC_END   = 5'h06;
   localparam logic [4:0]  LOW_SIG_FIRST = 5'h0E;
   localparam logic [4:0]  LOW_STEPS     = 5'h10;
   localparam logic [4:0]  HIGH_MAC_END  = 5'h03;
   localparam logic [4:0]  HIGH_SIG_STEP = 5'h07;
   localparam logic [4:0]  LAST_STEP     = 5'h17;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [15:0] data;
   } eal_sram_wr_t;

   typedef struct packed {
      logic        manual;
      logic        speed100;
      logic        full_duplex;
   } eal_phy_mode_t;

   typedef struct packed {
      logic csr_sel;
      logic autoload;
      logic pkt_buf;
      logic reserved;
   } eal_decode_t;
endpackage : eal_pkg

//--- logic/eal_loader.sv
// power-up configuration autoloader with csr and local memory decode
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - phy field 101, 110, 111 forces 100M half, 10M full and 10M half duplex.
// - effective interrupt type is the loaded type option ORed with bus-type bit 5.
// - a host write to the bus-type register once load_done is set clears both loaded interrupt options.
// - effective interrupt polarity is the loaded polarity option ORed with bit 4.
// - low-region signature filler bytes are 57h with the signature option set, else 42h.
// - word 1 gives the total word count and reading stops after that many words, or after word 1 for counts below 2.
// - host io offsets 0000h to 001Fh select the command and status registers.
// - 0000h-001Fh, 0400h-040Fh autoload, 4000h-7FFFh packet buffer, rest reserved.
// - low region holds each address byte doubled, zeros at 0Ch-1Ah, signature at 1Ch/1Eh.
// - high region packs address bytes two per word, zeros, then 57h doubled at 40Eh.
// - loading happens only when word 0 equals 5AA5h, otherwise it is skipped.
// - the loader writes only internal sram, never the station address registers.
// - without a valid pattern the phy stays in auto-negotiation with all abilities.
////////////////////////////////////////////////////////////////////////////////
module eal_loader (
   input  wire logic                   clk,
   input  wire logic                   rst,
   output logic                        eep_req,
   output logic [15:0]                 eep_addr,
   input  wire logic                   eep_ack,
   input  wire logic [15:0]            eep_data,
   output var eal_pkg::eal_sram_wr_t   sram_wr,
   input  wire logic                   bus_type_wr,
   input  wire logic                   bus_type_irq_type,
   input  wire logic                   bus_type_irq_pol,
   output logic                        irq_type_eff,
   output logic                        irq_pol_eff,
   output logic [2:0]                  phy_cfg,
   output var eal_pkg::eal_phy_mode_t  phy_mode,
   output logic                        eeprom_valid,
   output logic                        load_done,
   input  wire logic [15:0]            host_io_addr,
   input  wire logic [15:0]            mem_addr,
   output var eal_pkg::eal_decode_t    decode
);
   import eal_pkg::*;

   typedef enum logic [3:0] {
      ST_READ  = 4'h1,
      ST_WRITE = 4'h2,
      ST_DONE  = 4'h4,
      ST_SKIP  = 4'h8
   } eal_state_t;

   typedef struct packed {
      eal_state_t    state;
      logic [15:0]   idx;
      logic [15:0]   count;
      logic [47:0]   mac;
      logic [2:0]    phy;
      eal_phy_mode_t mode;
      logic          irq_type_option;
      logic          irq_polarity_option;
      logic          compat_signature_option;
      logic          valid;
      logic [4:0]    step;
      eal_sram_wr_t  wr;
      logic          type_eff;
      logic          pol_eff;
      logic          done;
   } eal_regs_t;

   eal_regs_t st_r;
   eal_regs_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] step_addr(input logic [4:0] s);
      logic [4:0] k;
      k = s - LOW_STEPS;
      if (s < LOW_STEPS) begin
         step_addr = {10'h000, s, 1'b0};
      end else begin
         step_addr = HIGH_BASE | {10'h000, k, 1'b0};
      end
   endfunction : step_addr

   function automatic logic [15:0] step_data(input logic [4:0]  s,
                                             input logic [47:0] mac,
                                             input logic        sig);
      logic [4:0] k;
      logic [7:0] sb;
      k  = s - LOW_STEPS;
      sb = sig ? SIG_SET : SIG_CLR;
      step_data = 16'h0000;
      if (s < LOW_STEPS) begin
         if (s < LOW_MAC_END) begin
            step_data = {2{mac[{s[2:0], 3'b000} +: 8]}};
         end else if (s >= LOW_SIG_FIRST) begin
            step_data = {sb, sb};
         end
      end else begin
         if (k < HIGH_MAC_END) begin
            step_data = mac[{k[1:0], 4'h0} +: 16];
         end else if (k == HIGH_SIG_STEP) begin
            step_data = {SIG_HIGH, SIG_HIGH};
         end
      end
   endfunction : step_data

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // manual modes only for the top half of the field; the rest auto-negotiates
   function automatic eal_phy_mode_t phy_decode(input logic [2:0] cfg);
      phy_decode = '0;
      unique case (cfg)
         PHY_M100_FDX: begin
            phy_decode = '{manual: 1'b1, speed100: 1'b1, full_duplex: 1'b1};
         end
         PHY_M100_HDX: begin
            phy_decode = '{manual: 1'b1, speed100: 1'b1, full_duplex: 1'b0};
         end
         PHY_M10_FDX: begin
            phy_decode = '{manual: 1'b1, speed100: 1'b0, full_duplex: 1'b1};
         end
         PHY_M10_HDX: begin
            phy_decode = '{manual: 1'b1, speed100: 1'b0, full_duplex: 1'b0};
         end
         default: begin
            phy_decode = '0;
         end
      endcase
   endfunction : phy_decode

   // true once the word just taken is the last one the count asks for;
   // a count of two or less still ends only after word 1
   function automatic logic read_ends(input logic [15:0] idx,
                                      input logic [15:0] cnt,
                                      input logic [15:0] data);
      logic [15:0] nxt_idx;
      nxt_idx = idx + 16'h0001;
      if (idx == WORD_PATTERN) begin
         read_ends = 1'b0;
      end else if (idx == WORD_COUNT) begin
         read_ends = data <= nxt_idx;
      end else begin
         read_ends = nxt_idx >= cnt;
      end
   endfunction : read_ends

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt       = st_r;
      st_nxt.wr.we = 1'b0;
      unique case (st_r.state)
         ST_READ: begin
            if (eep_ack) begin
               st_nxt.idx = st_r.idx + 16'h0001;
               if (st_r.idx == WORD_PATTERN) begin
                  if (eep_data != PATTERN) begin
                     st_nxt.state = ST_SKIP;
                  end
               end else if (st_r.idx == WORD_COUNT) begin
                  st_nxt.count = eep_data;
               end else if (st_r.idx == WORD_OPT) begin
                  st_nxt.phy                     = eep_data[OPT_PHY_LSB +: 3];
                  st_nxt.irq_type_option         = eep_data[OPT_TYPE_BIT];
                  st_nxt.irq_polarity_option     = eep_data[OPT_POL_BIT];
                  st_nxt.compat_signature_option = eep_data[OPT_SIG_BIT];
               end else if (st_r.idx >= WORD_MAC0 && st_r.idx <= WORD_MAC2) begin
                  st_nxt.mac[{st_r.idx[1:0] - 2'h3, 4'h0} +: 16] = eep_data;
               end
               // count read from word 1 bounds the walk; short images leave zeros
               if (read_ends(st_r.idx, st_r.count, eep_data)) begin
                  st_nxt.state = ST_WRITE;
               end
            end
         end
         ST_WRITE: begin
            // only sram is written; station address registers stay host-owned
            st_nxt.wr.we   = 1'b1;
            st_nxt.wr.addr = step_addr(st_r.step);
            st_nxt.wr.data = step_data(st_r.step, st_r.mac, st_r.compat_signature_option);
            st_nxt.step    = st_r.step + 5'h01;
            if (st_r.step == LAST_STEP) begin
               st_nxt.state = ST_DONE;
               st_nxt.valid = 1'b1;
            end
         end
         ST_SKIP: begin
            // no pattern: options stay at reset values, phy auto-negotiates
            st_nxt.phy                 = PHY_AUTO_ALL;
            st_nxt.irq_type_option     = 1'b0;
            st_nxt.irq_polarity_option = 1'b0;
            st_nxt.state               = ST_DONE;
         end
         ST_DONE: begin
            st_nxt.done = 1'b1;
         end
      endcase
      // host writes clear the loaded options only once load_done is set, so a write during
      // loading cannot lose them
      if (bus_type_wr && st_r.done) begin
         st_nxt.irq_type_option     = 1'b0;
         st_nxt.irq_polarity_option = 1'b0;
      end
      st_nxt.type_eff = bus_type_irq_type | st_nxt.irq_type_option;
      st_nxt.pol_eff  = bus_type_irq_pol | st_nxt.irq_polarity_option;
      // mode registered beside the field so both change on the same edge
      st_nxt.mode     = phy_decode(st_nxt.phy);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r       <= '0;
         st_r.state <= ST_READ;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode is combinational so a select follows its address in the same cycle
   always_comb begin
      decode.csr_sel  = host_io_addr <= CSR_LAST;
      decode.autoload = in_range(mem_addr, 16'h0000, LOW_LAST)
                      | in_range(mem_addr, HIGH_BASE, HIGH_LAST);
      decode.pkt_buf  = in_range(mem_addr, BUF_BASE, BUF_LAST);
      decode.reserved = ~(decode.autoload | decode.pkt_buf);
   end

   assign eep_req      = st_r.state == ST_READ;
   assign eep_addr     = st_r.idx;
   assign sram_wr      = st_r.wr;
   assign irq_type_eff = st_r.type_eff;
   assign irq_pol_eff  = st_r.pol_eff;
   assign phy_cfg      = st_r.phy;
   assign phy_mode     = st_r.mode;
   assign eeprom_valid = st_r.valid;
   assign load_done    = st_r.done;
endmodule : eal_loader
`default_nettype wire

//--- tb/eal_eeprom_model.sv
// eeprom word source answering the loader read handshake
`timescale 1ns/10ps
`default_nettype none
module eal_eeprom_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        eep_req,
   input  wire logic [15:0] eep_addr,
   input  wire logic [15:0] img [8],
   output logic             eep_ack,
   output logic [15:0]      eep_data
);
   logic [1:0] wait_r;
   assign eep_ack = eep_req && (!slow || wait_r == 2'h3);
   // inverted word between answers so an early sample never looks right
   assign eep_data = eep_ack ? img[eep_addr[2:0]] : ~img[eep_addr[2:0]];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wait_r <= 2'h0;
      else wait_r <= (eep_ack || !eep_req) ? 2'h0 : wait_r + 2'h1;
   end
endmodule : eal_eeprom_model
`default_nettype wire

//--- tb/eal_loader_asserts.sv
// concurrent checks on the configuration autoloader ports
`timescale 1ns/10ps
`default_nettype none
module eal_loader_asserts
   import eal_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   eep_req,
   input wire logic [15:0]            eep_addr,
   input wire logic                   eep_ack,
   input wire logic [15:0]            eep_data,
   input wire eal_pkg::eal_sram_wr_t  sram_wr,
   input wire logic                   bus_type_wr,
   input wire logic                   bus_type_irq_type,
   input wire logic                   bus_type_irq_pol,
   input wire logic                   irq_type_eff,
   input wire logic                   irq_pol_eff,
   input wire logic [2:0]             phy_cfg,
   input wire eal_pkg::eal_phy_mode_t phy_mode,
   input wire logic                   eeprom_valid,
   input wire logic                   load_done,
   input wire logic [15:0]            host_io_addr,
   input wire logic [15:0]            mem_addr,
   input wire eal_pkg::eal_decode_t   decode
);
   logic auto_w;
   logic buf_w;
   assign auto_w = mem_addr <= 16'h001F || mem_addr inside {[16'h0400:16'h040F]};
   assign buf_w = mem_addr inside {[16'h4000:16'h7FFF]};
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_PHY_MODE: assert property (
      phy_mode == {phy_cfg[2], phy_cfg[2:1] == 2'h2, phy_cfg[2] & ~phy_cfg[0]})
      else $error("phy mode wrong");
   AST_AUTO_NEG: assert property (
      load_done && !eeprom_valid |-> phy_cfg == 3'h0) else $error("phy not auto");
   AST_IRQ_OR: assert property (
      !$past(rst) |-> irq_type_eff >= $past(bus_type_irq_type)
      && irq_pol_eff >= $past(bus_type_irq_pol))
      else $error("irq option or lost");
   AST_HOST_CLEAR: assert property (
      load_done && bus_type_wr |=> ##1 irq_type_eff == $past(bus_type_irq_type)
      && irq_pol_eff == $past(bus_type_irq_pol)) else $error("options not cleared");
   AST_WR_PLACE: assert property (
      sram_wr.we |-> !sram_wr.addr[0] && (sram_wr.addr <= 16'h001E
      || sram_wr.addr inside {[16'h0400:16'h040E]})) else $error("write outside load area");
   AST_ZERO_FILL: assert property (
      sram_wr.we && sram_wr.addr inside {[16'h0010:16'h001A], [16'h0406:16'h040C]}
      |-> sram_wr.data == 16'h0000) else $error("fill not zero");
   AST_HIGH_SIG: assert property (
      sram_wr.we && sram_wr.addr == 16'h040E |-> sram_wr.data == 16'h5757)
      else $error("high signature wrong");
   AST_DECODE: assert property (
      decode == {host_io_addr <= 16'h001F, auto_w, buf_w, !(auto_w || buf_w)})
      else $error("decode wrong");
   AST_ADDR_STEP: assert property (
      eep_req && eep_ack |=> eep_addr == $past(eep_addr) + 16'h0001)
      else $error("word order wrong");
   AST_SKIP: assert property (
      eep_req && eep_ack && eep_addr == 16'h0000 && eep_data != PATTERN
      |-> ##[1:4] load_done && !eeprom_valid) else $error("bad pattern not skipped");
endmodule : eal_loader_asserts
bind eal_loader eal_loader_asserts i_chk (.*);
`default_nettype wire

//--- tb/eal_loader_bench.sv
// self-checking bench for the configuration autoloader
`timescale 1ns/10ps
`default_nettype none
module eal_loader_bench;
   import eal_pkg::*;
   logic          clk = 1'b0, rst = 1'b1, slow = 1'b0, bus_type_wr = 1'b0;
   logic          bus_type_irq_type = 1'b0, bus_type_irq_pol = 1'b0;
   logic [15:0]   host_io_addr = 16'h0000, mem_addr = 16'h0000;
   logic          eep_req, eep_ack, irq_type_eff, irq_pol_eff, eeprom_valid, load_done;
   logic [15:0]   eep_addr, eep_data, img [8];
   logic [2:0]    phy_cfg;
   eal_sram_wr_t  sram_wr;
   eal_phy_mode_t phy_mode;
   eal_decode_t   decode;
   logic [15:0]   mem [logic [15:0]];
   int            bad_count = 0, checks = 0;
   always #2.5 clk = ~clk;
   eal_loader i_dut (.*);
   eal_eeprom_model i_eep (.*);
   // sram image as the loader leaves it
   always @(posedge clk) if (sram_wr.we === 1'b1) mem[sram_wr.addr] = sram_wr.data;
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic close_out;
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic boot(input logic [15:0] w0, input logic [15:0] n, input logic [15:0] opt);
      int i;
      img = '{w0, n, opt, 16'h3210, 16'h7654, 16'hBA98, 16'h1111, 16'h2222};
      mem.delete();
      rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      for (i = 0; i < 300 && load_done !== 1'b1; i++) @(posedge clk) #1;
      if (load_done !== 1'b1) begin
         bad_count++;
         close_out();
      end
      repeat (2) @(posedge clk) #1;
   endtask : boot
   task automatic t_load(input logic [15:0] opt, input logic [15:0] n, input logic lag,
                         input logic [2:0] pm);
      logic [7:0] b [6];
      logic [7:0] s;
      int         k;
      slow = lag;
      boot(PATTERN, n, opt);
      // words past the count stay unread, so their bytes land as zero
      for (k = 0; k < 6; k++) b[k] = (k / 2 + 3 < n) ? img[k / 2 + 3][8 * (k % 2) +: 8] : 8'h00;
      s = opt[2] ? 8'h57 : 8'h42;
      chk(16'(mem.num()), 16'h0018);
      for (k = 0; k < 16; k++) chk(mem[16'(2 * k)], k < 6 ? {b[k], b[k]} : k > 13 ? {s, s} : 16'h0000);
      for (k = 0; k < 8; k++) chk(mem[16'(16'h0400 + 2 * k)], k < 3 ? {b[2 * k + 1], b[2 * k]} : k == 7 ? 16'h5757 : 16'h0000);
      chk(16'({eeprom_valid, phy_mode, phy_cfg}), 16'({1'b1, pm, opt[10:8]}));
      chk(16'({irq_type_eff, irq_pol_eff}), 16'(opt[5:4]));
      bus_type_wr = 1'b1;
      @(posedge clk);
      #1 bus_type_wr = 1'b0;
      bus_type_irq_type = 1'b1;
      repeat (2) @(posedge clk) #1;
      chk(16'({irq_type_eff, irq_pol_eff}), 16'h0002);
      bus_type_irq_type = 1'b0;
   endtask : t_load
   task automatic t_skip;
      boot(16'hA55A, 16'h0006, 16'h0734);
      chk(16'(mem.num()), 16'h0000);
      chk(16'({eeprom_valid, phy_mode, phy_cfg, irq_type_eff}), 16'h0000);
   endtask : t_skip
   task automatic t_decode;
      logic [15:0] a [6] = '{16'h001F, 16'h0020, 16'h040F, 16'h0410, 16'h7FFF, 16'h8000};
      logic [3:0]  d [6] = '{4'hC, 4'h1, 4'h4, 4'h1, 4'h2, 4'h1};
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         #1 host_io_addr = a[k];
         mem_addr = a[k];
         #1 chk(16'(decode), 16'(d[k]));
      end
   endtask : t_decode
   initial begin
      t_decode();
      t_load(16'h0534, 16'h0006, 1'b0, 3'b110);
      t_load(16'h0600, 16'h0004, 1'b1, 3'b101);
      t_load(16'h0724, 16'h0006, 1'b1, 3'b100);
      // count of three stops after the option word: manual 100 full, no address
      t_load(16'h0400, 16'h0003, 1'b0, 3'b111);
      t_skip();
      close_out();
   end
endmodule : eal_loader_bench
`default_nettype wire
